// file: rtl/fdc_dev_end.sv
`timescale 1ns/1ps
`include "fdc_consts.svh"
module fdc_dev_end #(
	parameter int unsigned SETTLE_CYCLES = `SETTLE_US * `CLK_MHZ
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// host link
	fdc_link_if.dev link,
	// drive read path
	input wire logic index_i,
	input wire logic id_valid_i,
	input wire logic [7:0] id_c_i,
	input wire logic [7:0] id_h_i,
	input wire logic [7:0] id_r_i,
	input wire logic [7:0] id_n_i,
	input wire logic id_crc_ok_i,
	input wire logic mark_valid_i,
	input wire logic mark_deleted_i,
	input wire logic rd_valid_i,
	input wire logic [7:0] rd_byte_i,
	// drive write path
	input wire logic byte_tick_i,
	output logic head_load_o,
	output logic head_sel_o,
	output logic mfm_o,
	output logic wr_gate_o,
	output logic wr_strobe_o,
	output fdc_pkg::wr_mark_t wr_mark_o,
	output logic [7:0] wr_byte_o
);
	import fdc_pkg::*;

	localparam int unsigned OVR_FM_CYC = `OVR_FM_US * `CLK_MHZ;
	localparam int unsigned OVR_MFM_CYC = `OVR_MFM_US * `CLK_MHZ;

	logic [7:0] cmd_q [0:8];
	logic [3:0] ccnt_q;
	dev_state_t st_q;
	fmt_ph_t ph_q;
	logic [7:0] c_q, h_q, r_q, n_q, st0_q, st1_q, st2_q, sect_q, hold_q, dout_q, res_q;
	logic [15:0] bcnt_q;
	logic [19:0] settle_q;
	logic [10:0] ovr_q;
	logic [2:0] rcnt_q;
	logic [1:0] fk_q;
	logic idx_edge, idx_s1_q, idx_s2_q, idx_s3_q, idx_q;
	logic tc_seen_q, mark_pend_q, cm_pend_q, found_q, match_q, head_q, hold_full_q, drq_q;
	logic to_host_q, res_valid_q, gate_q, strobe_q, ovr_hit, last, id_match, dack_ok;
	wr_mark_t mark_q;
	logic [4:0] op;
	logic [3:0] need;
	logic [7:0] end_of_track_sector, sz, gap_length, nid_c, nid_h, nid_r;
	logic [15:0] len;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign op = cmd_q[0][4:0];
	assign end_of_track_sector = cmd_q[6];
	assign sz = (op == `OP_FORMAT) ? cmd_q[2] : cmd_q[5];
	assign gap_length = (op == `OP_FORMAT) ? cmd_q[4] : cmd_q[7];
	assign len = (op != `OP_FORMAT && sz == 8'h00) ? {8'h00, cmd_q[8]} : (`SECT_BASE << sz[2:0]);
	assign last = (bcnt_q == len - 16'h0001);
	assign id_match = {id_c_i, id_h_i, id_r_i, id_n_i} == {c_q, h_q, r_q, n_q};
	assign idx_edge = idx_s2_q & ~idx_s3_q;
	assign dack_ok = link.dack & drq_q;

	always_comb
	begin
		unique case (op)
			`OP_WRITE, `OP_WRDEL, `OP_RDDEL, `OP_TRACK: need = `CMD_LEN_RW;
			`OP_RDID: need = `CMD_LEN_RID;
			`OP_FORMAT: need = `CMD_LEN_FMT;
			default: need = `CMD_LEN_BAD;
		endcase
	end

	always_comb
	begin
		nid_c = c_q;
		nid_h = h_q;
		nid_r = r_q + 8'h01;
		if (r_q == end_of_track_sector)
		begin
			nid_r = `FIRST_SECTOR;
			if (!cmd_q[0][`MT_BIT] || h_q[0])
				nid_c = c_q + 8'h01;
			if (cmd_q[0][`MT_BIT])
				nid_h = {h_q[7:1], ~h_q[0]};
		end
	end

	// ----------------------------------------
	// index synchroniser
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			{idx_s1_q, idx_s2_q, idx_s3_q} <= 3'h0;
		else
			{idx_s1_q, idx_s2_q, idx_s3_q} <= {index_i, idx_s1_q, idx_s2_q};
	end

	// ----------------------------------------
	// host service timer
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ovr_q <= 11'h000;
		else if (!drq_q || link.dack)
			ovr_q <= 11'h000;
		else if (!ovr_hit)
			ovr_q <= ovr_q + 11'h001;
	end
	assign ovr_hit = drq_q && (ovr_q == (cmd_q[0][`MF_BIT] ? 11'(OVR_MFM_CYC - 1) : 11'(OVR_FM_CYC - 1)));

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 9; i++)
				cmd_q[i] <= 8'h00;
			{ccnt_q, rcnt_q, fk_q} <= 9'h000;
			{c_q, h_q, r_q, n_q, st0_q, st1_q, st2_q, sect_q, hold_q, dout_q, res_q} <= 88'h0;
			{bcnt_q, settle_q} <= 36'h0;
			{idx_q, tc_seen_q, mark_pend_q, cm_pend_q, found_q, match_q, head_q, hold_full_q} <= 8'h00;
			{drq_q, to_host_q, res_valid_q, gate_q, strobe_q} <= 5'h00;
			mark_q <= MARK_NONE;
			ph_q <= PH_GAP1;
			st_q <= S_IDLE;
		end
		else
		begin
			strobe_q <= 1'b0;
			res_valid_q <= 1'b0;
			if (link.tc && st_q != S_IDLE && st_q != S_CMD)
				tc_seen_q <= 1'b1;
			if (dack_ok)
			begin
				drq_q <= 1'b0;
				hold_q <= link.host_data;
				hold_full_q <= 1'b1;
			end
			unique case (st_q)
				S_IDLE:
					if (link.cmd_valid)
					begin
						cmd_q[0] <= link.cmd_byte;
						ccnt_q <= 4'h1;
						st_q <= S_CMD;
					end
				S_CMD:
					if (ccnt_q == need)
					begin
						{c_q, h_q, r_q, n_q} <= {cmd_q[2], cmd_q[3], cmd_q[4], cmd_q[5]};
						{st1_q, st2_q, sect_q, bcnt_q} <= 40'h0;
						st0_q <= {5'h00, cmd_q[1][2:0]};
						{tc_seen_q, idx_q, found_q, match_q, cm_pend_q, hold_full_q, drq_q} <= 7'h00;
						to_host_q <= (op == `OP_RDDEL || op == `OP_TRACK);
						settle_q <= 20'h00000;
						head_q <= 1'b1;
						if (need == `CMD_LEN_BAD)
						begin
							st0_q <= `ST0_ABN;
							st_q <= S_RES;
						end
						else
							st_q <= head_q ? S_SETTLE : S_SETTLE;
					end
					else if (link.cmd_valid)
					begin
						cmd_q[ccnt_q] <= link.cmd_byte;
						ccnt_q <= ccnt_q + 4'h1;
					end
				S_SETTLE:
					if (settle_q >= 20'(SETTLE_CYCLES - 1))
						unique case (op)
							`OP_TRACK: st_q <= S_TRK_IDX;
							`OP_FORMAT: st_q <= S_FMT_IDX;
							default: st_q <= S_SEARCH;
						endcase
					else
						settle_q <= settle_q + 20'h00001;
				S_SEARCH:
					if (idx_edge && idx_q)
					begin
						st1_q <= st1_q | `ST1_ND | ((op == `OP_RDID) ? `ST1_MA : 8'h00);
						st0_q <= st0_q | `ST0_ABN;
						st_q <= S_RES;
					end
					else if (idx_edge)
						idx_q <= 1'b1;
					else if (id_valid_i && op == `OP_RDID)
					begin
						if (id_crc_ok_i)
						begin
							{c_q, h_q, r_q, n_q} <= {id_c_i, id_h_i, id_r_i, id_n_i};
							st_q <= S_RES;
						end
					end
					else if (id_valid_i && !id_crc_ok_i)
					begin
						st1_q <= st1_q | `ST1_DE;
						st0_q <= st0_q | `ST0_ABN;
						st_q <= S_RES;
					end
					else if (id_valid_i && id_match)
					begin
						bcnt_q <= 16'h0000;
						if (op == `OP_RDDEL)
							st_q <= S_MARK;
						else
						begin
							mark_pend_q <= 1'b1;
							gate_q <= 1'b1;
							drq_q <= ~tc_seen_q;
							st_q <= S_WR;
						end
					end
				S_MARK:
					if (mark_valid_i)
					begin
						if (op == `OP_TRACK || mark_deleted_i)
							st_q <= S_RD;
						else if (cmd_q[0][`SK_BIT])
						begin
							r_q <= r_q + 8'h01;
							idx_q <= 1'b0;
							st_q <= S_SEARCH;
						end
						else
						begin
							cm_pend_q <= 1'b1;
							st_q <= S_RD;
						end
					end
				S_WR:
					if (byte_tick_i)
					begin
						strobe_q <= 1'b1;
						if (mark_pend_q)
						begin
							mark_q <= (op == `OP_WRDEL) ? MARK_DELETED : MARK_DATA;
							dout_q <= 8'h00;
							mark_pend_q <= 1'b0;
						end
						else
						begin
							mark_q <= MARK_NONE;
							dout_q <= hold_full_q ? hold_q : 8'h00;
							if (hold_full_q)
								hold_full_q <= 1'b0;
							bcnt_q <= bcnt_q + 16'h0001;
							if (last)
							begin
								gate_q <= 1'b0;
								if (tc_seen_q || r_q == end_of_track_sector)
								begin
									{c_q, h_q, r_q} <= {nid_c, nid_h, nid_r};
									st_q <= S_RES;
								end
								else
								begin
									r_q <= r_q + 8'h01;
									idx_q <= 1'b0;
									st_q <= S_SEARCH;
								end
							end
							else if (!tc_seen_q)
								drq_q <= 1'b1;
						end
					end
				S_RD:
					if (rd_valid_i)
					begin
						bcnt_q <= bcnt_q + 16'h0001;
						if (!tc_seen_q)
						begin
							dout_q <= rd_byte_i;
							drq_q <= 1'b1;
							if (drq_q && !link.dack)
							begin
								st1_q <= st1_q | `ST1_OR;
								st0_q <= st0_q | `ST0_ABN;
								st_q <= S_RES;
							end
						end
						if (last && op == `OP_TRACK)
						begin
							sect_q <= sect_q + 8'h01;
							if (sect_q + 8'h01 == end_of_track_sector)
							begin
								st1_q <= st1_q | (match_q ? 8'h00 : `ST1_ND);
								st_q <= S_RES;
							end
							else
								st_q <= S_TRK;
						end
						else if (last && cm_pend_q)
						begin
							st2_q <= st2_q | `ST2_CM;
							st_q <= S_RES;
						end
						else if (last && (tc_seen_q || r_q == end_of_track_sector))
						begin
							{c_q, h_q, r_q} <= {nid_c, nid_h, nid_r};
							st_q <= S_RES;
						end
						else if (last)
						begin
							r_q <= r_q + 8'h01;
							idx_q <= 1'b0;
							st_q <= S_SEARCH;
						end
					end
				S_TRK_IDX:
					if (idx_edge)
						st_q <= S_TRK;
				S_TRK:
					if (idx_edge && !found_q)
					begin
						st1_q <= st1_q | `ST1_MA;
						st0_q <= st0_q | `ST0_ABN;
						st_q <= S_RES;
					end
					else if (id_valid_i)
					begin
						found_q <= 1'b1;
						if (id_match)
							match_q <= 1'b1;
						bcnt_q <= 16'h0000;
						st_q <= S_MARK;
					end
				S_FMT_IDX:
					if (idx_edge)
					begin
						fk_q <= 2'h0;
						drq_q <= 1'b1;
						st_q <= S_FMT_REQ;
					end
				S_FMT_REQ:
					if (idx_edge)
					begin
						drq_q <= 1'b0;
						st_q <= S_RES;
					end
					else if (dack_ok)
					begin
						unique case (fk_q)
							2'h0: c_q <= link.host_data;
							2'h1: h_q <= link.host_data;
							2'h2: r_q <= link.host_data;
							2'h3: n_q <= link.host_data;
						endcase
						fk_q <= fk_q + 2'h1;
						if (fk_q == 2'h3)
						begin
							gate_q <= 1'b1;
							ph_q <= PH_GAP1;
							bcnt_q <= 16'h0000;
							st_q <= S_FMT_WR;
						end
						else
							drq_q <= 1'b1;
					end
				S_FMT_WR:
					if (idx_edge)
					begin
						gate_q <= 1'b0;
						st_q <= S_RES;
					end
					else if (byte_tick_i)
					begin
						strobe_q <= 1'b1;
						mark_q <= MARK_NONE;
						bcnt_q <= bcnt_q + 16'h0001;
						unique case (ph_q)
							PH_GAP1, PH_GAP2:
							begin
								dout_q <= `GAP_BYTE;
								if (bcnt_q + 16'h0001 >= {8'h00, gap_length})
								begin
									bcnt_q <= 16'h0000;
									ph_q <= (ph_q == PH_GAP1) ? PH_IDAM : PH_DAM;
								end
							end
							PH_IDAM, PH_DAM:
							begin
								mark_q <= (ph_q == PH_IDAM) ? MARK_ID : MARK_DATA;
								dout_q <= 8'h00;
								bcnt_q <= 16'h0000;
								ph_q <= (ph_q == PH_IDAM) ? PH_ID : PH_FILL;
							end
							PH_ID:
							begin
								dout_q <= (bcnt_q[1:0] == 2'h0) ? c_q : (bcnt_q[1:0] == 2'h1) ? h_q :
									(bcnt_q[1:0] == 2'h2) ? r_q : n_q;
								if (bcnt_q[1:0] == 2'h3)
								begin
									bcnt_q <= 16'h0000;
									ph_q <= PH_GAP2;
								end
							end
							PH_FILL:
							begin
								dout_q <= cmd_q[5];
								if (last)
								begin
									r_q <= r_q + 8'h01;
									sect_q <= sect_q + 8'h01;
									fk_q <= 2'h0;
									drq_q <= 1'b1;
									st_q <= S_FMT_REQ;
								end
							end
						endcase
					end
				S_RES:
					if (!drq_q)
					begin
						res_valid_q <= 1'b1;
						res_q <= (rcnt_q == 3'h0) ? st0_q : (rcnt_q == 3'h1) ? st1_q : (rcnt_q == 3'h2) ? st2_q :
							(rcnt_q == 3'h3) ? c_q : (rcnt_q == 3'h4) ? h_q : (rcnt_q == 3'h5) ? r_q : n_q;
						rcnt_q <= rcnt_q + 3'h1;
						if (rcnt_q == `RES_LEN - 3'h1)
						begin
							rcnt_q <= 3'h0;
							st_q <= S_IDLE;
						end
					end
			endcase
			if (ovr_hit && st_q != S_RES)
			begin
				st1_q <= st1_q | `ST1_OR;
				st0_q <= st0_q | `ST0_ABN;
				gate_q <= 1'b0;
				drq_q <= 1'b0;
				st_q <= S_RES;
			end
			else if (ovr_hit)
				drq_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign link.drq = drq_q;
	assign link.to_host = to_host_q;
	assign link.dev_data = dout_q;
	assign link.res_valid = res_valid_q;
	assign link.res_byte = res_q;
	assign link.busy = (st_q != S_IDLE);
	assign head_load_o = head_q;
	assign head_sel_o = cmd_q[1][`HD_BIT];
	assign mfm_o = cmd_q[0][`MF_BIT];
	assign wr_gate_o = gate_q;
	assign wr_strobe_o = strobe_q;
	assign wr_mark_o = mark_q;
	assign wr_byte_o = dout_q;
endmodule

// file: rtl/fdc_consts.svh
`ifndef FDC_CONSTS_SVH
`define FDC_CONSTS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 25
`define OVR_FM_US 27
`define OVR_MFM_US 13
`define SETTLE_US 16000
// ----------------------------------------
// command opcodes and lengths
// ----------------------------------------
`define OP_WRITE 5'h05
`define OP_WRDEL 5'h09
`define OP_RDDEL 5'h0c
`define OP_TRACK 5'h02
`define OP_RDID 5'h0a
`define OP_FORMAT 5'h0d
`define CMD_LEN_RW 4'h9
`define CMD_LEN_FMT 4'h6
`define CMD_LEN_RID 4'h2
`define CMD_LEN_BAD 4'h1
`define MT_BIT 7
`define MF_BIT 6
`define SK_BIT 5
`define HD_BIT 2
// ----------------------------------------
// status bits
// ----------------------------------------
`define ST0_ABN 8'h40
`define ST1_MA 8'h01
`define ST1_ND 8'h04
`define ST1_OR 8'h10
`define ST1_DE 8'h20
`define ST2_CM 8'h40
// ----------------------------------------
// track layout
// ----------------------------------------
`define GAP_BYTE 8'h4e
`define SECT_BASE 16'h0080
`define FIRST_SECTOR 8'h01
`define RES_LEN 3'h7
// ----------------------------------------
// host register map
// ----------------------------------------
`define HR_CMD 4'h0
`define HR_DATA 4'h1
`define HR_STATUS 4'h2
`define HR_CTRL 4'h3
`define HR_RES0 4'h8
`endif

// file: rtl/fdc_pkg.sv
package fdc_pkg;
	typedef enum logic [1:0] {MARK_NONE, MARK_ID, MARK_DATA, MARK_DELETED} wr_mark_t;
	typedef enum {S_IDLE, S_CMD, S_SETTLE, S_SEARCH, S_MARK, S_WR, S_RD, S_TRK_IDX, S_TRK, S_FMT_IDX,
		S_FMT_REQ, S_FMT_WR, S_RES} dev_state_t;
	typedef enum {PH_GAP1, PH_IDAM, PH_ID, PH_GAP2, PH_DAM, PH_FILL} fmt_ph_t;
endpackage

// file: rtl/fdc_link_if.sv
`timescale 1ns/1ps
interface fdc_link_if;
	logic cmd_valid;
	logic [7:0] cmd_byte;
	logic drq;
	logic to_host;
	logic dack;
	logic [7:0] host_data;
	logic [7:0] dev_data;
	logic tc;
	logic res_valid;
	logic [7:0] res_byte;
	logic busy;
	modport dev (input cmd_valid, cmd_byte, dack, host_data, tc,
		output drq, to_host, dev_data, res_valid, res_byte, busy);
	modport host (output cmd_valid, cmd_byte, dack, host_data, tc,
		input drq, to_host, dev_data, res_valid, res_byte, busy);
endinterface

// file: rtl/fdc_host_end.sv
`timescale 1ns/1ps
`include "fdc_consts.svh"
module fdc_host_end (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// device link
	fdc_link_if.host link,
	// software port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o
);
	import fdc_pkg::*;

	logic [7:0] res_q [0:6];
	logic [2:0] rptr_q;
	logic [7:0] cmd_q, tx_q, rx_q, rdata_q;
	logic cmd_valid_q, tx_full_q, rx_full_q, tc_arm_q, dack_q, tc_q, take;

	// ----------------------------------------
	// data request service
	// ----------------------------------------
	assign take = link.drq && !dack_q && (link.to_host ? !rx_full_q : tx_full_q);

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			{dack_q, tc_q, tx_full_q, rx_full_q, tc_arm_q, cmd_valid_q} <= 6'h00;
			{cmd_q, tx_q, rx_q} <= 24'h0;
		end
		else
		begin
			dack_q <= take;
			tc_q <= take && tc_arm_q;
			cmd_valid_q <= wr_i && addr_i == `HR_CMD;
			if (wr_i && addr_i == `HR_CMD)
				cmd_q <= wdata_i;
			if (rd_i && addr_i == `HR_DATA)
				rx_full_q <= 1'b0;
			if (take && link.to_host)
			begin
				rx_q <= link.dev_data;
				rx_full_q <= 1'b1;
			end
			if (take && !link.to_host)
				tx_full_q <= 1'b0;
			if (wr_i && addr_i == `HR_DATA)
			begin
				tx_q <= wdata_i;
				tx_full_q <= 1'b1;
			end
			if (take && tc_arm_q)
				tc_arm_q <= 1'b0;
			if (wr_i && addr_i == `HR_CTRL)
				tc_arm_q <= wdata_i[0];
		end
	end

	// ----------------------------------------
	// result capture and read port
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 7; i++)
				res_q[i] <= 8'h00;
			rptr_q <= 3'h0;
		end
		else if (link.res_valid)
		begin
			res_q[rptr_q] <= link.res_byte;
			rptr_q <= (rptr_q == `RES_LEN - 3'h1) ? 3'h0 : rptr_q + 3'h1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_q <= 8'h00;
		else if (rd_i && addr_i == `HR_DATA)
			rdata_q <= rx_q;
		else if (rd_i && addr_i == `HR_STATUS)
			rdata_q <= {2'h0, tc_arm_q, tx_full_q, rx_full_q, link.to_host, link.drq, link.busy};
		else if (rd_i && addr_i >= `HR_RES0 && addr_i < `HR_RES0 + 4'(`RES_LEN))
			rdata_q <= res_q[3'(addr_i - `HR_RES0)];
		else if (rd_i)
			rdata_q <= 8'h00;
	end

	assign rdata_o = rdata_q;
	assign link.cmd_valid = cmd_valid_q;
	assign link.cmd_byte = cmd_q;
	assign link.dack = dack_q;
	assign link.host_data = tx_q;
	assign link.tc = tc_q;
endmodule

// file: tb/fdc_link_checker.sv
`timescale 1ns/1ps
module fdc_link_checker (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// link signals
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic drq,
	input wire logic to_host,
	input wire logic dack,
	input wire logic [7:0] dev_data,
	input wire logic tc,
	input wire logic res_valid,
	input wire logic [7:0] res_byte,
	input wire logic busy
);
	// ------
	// command and wait tracking
	// ------
	logic [3:0] n_cmd_q;
	logic [4:0] op_q;
	logic mfm_q;
	logic [9:0] wait_q;
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			n_cmd_q <= 4'h0;
			op_q <= 5'h00;
			mfm_q <= 1'b0;
		end
		else if (res_valid)
			n_cmd_q <= 4'h0;
		else if (cmd_valid)
		begin
			n_cmd_q <= n_cmd_q + 4'h1;
			if (n_cmd_q == 4'h0)
			begin
				op_q <= cmd_byte[4:0];
				mfm_q <= cmd_byte[6];
			end
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			wait_q <= 10'h000;
		else
			wait_q <= (drq && !dack) ? wait_q + 10'h001 : 10'h000;
	end
	// ------
	// properties
	// ------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_res_burst;
		res_valid [*7] ##1 !res_valid;
	endsequence
	sequence s_st0_normal;
		$rose(res_valid) && res_byte[7:6] == 2'h0;
	endsequence
	AST_RES_BURST: assert property ($rose(res_valid) |-> s_res_burst)
		else $error("result burst is not seven bytes");
	AST_BUSY_END: assert property ($fell(res_valid) |-> ##[0:2] !busy)
		else $error("busy stays after results");
	AST_WR_NINE: assert property (drq && !to_host && (op_q == 5'h05 || op_q == 5'h09) |-> n_cmd_q == 4'h9)
		else $error("write request before nine command bytes");
	AST_RDID_QUIET: assert property (op_q == 5'h0a && n_cmd_q == 4'h2 |-> !drq)
		else $error("data request during read id");
	AST_OVR_BOUND: assert property (wait_q <= (mfm_q ? 10'h145 : 10'h2a3))
		else $error("request stands past overrun limit");
	AST_OVR_END: assert property (mfm_q && wait_q == 10'h144 && drq && !dack |-> ##[1:40] $rose(res_valid))
		else $error("no results after overrun");
	AST_TC_PAIR: assert property (tc |-> dack)
		else $error("terminal count without byte");
	AST_DACK_DRQ: assert property (dack |-> drq)
		else $error("byte given without request");
	AST_ST0_FORM: assert property ($rose(res_valid) |-> !res_byte[7])
		else $error("status 0 bit 7 set");
	AST_ST1_CLEAN: assert property (s_st0_normal |=> res_byte == 8'h00)
		else $error("error flag with normal end");
	AST_RD_STABLE: assert property (drq && to_host && !dack |=> !drq || $stable(dev_data))
		else $error("offered byte changed");
endmodule

// file: tb/floppy_write_format_cmd_exec_test.sv
`timescale 1ns/1ps
module floppy_write_format_cmd_exec_test;
	import fdc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic index = 1'b0;
	logic id_valid = 1'b0;
	logic [31:0] id_chrn = 32'h0;
	logic crc_ok = 1'b0;
	logic mark_valid = 1'b0;
	logic mark_del = 1'b0;
	logic head_load, head_sel, mfm, wr_gate;
	logic rd_valid = 1'b0;
	logic [7:0] rd_byte = 8'h00;
	logic byte_tick = 1'b0;
	logic [1:0] tick_q = 2'h0;
	logic wr_strobe;
	wr_mark_t wr_mark;
	logic [7:0] wr_byte;
	logic [31:0] seed = 32'hd095;
	logic [7:0] v;
	logic [7:0] cb[$];
	logic [9:0] wq[$];
	logic [9:0] sq[$];
	logic [9:0] rq[$];
	int fails = 0;
	int n_tests = 0;
	fdc_link_if link();
	fdc_dev_end #(.SETTLE_CYCLES(4)) fdc_dev_end_i (.ref_clk_i(clk), .rst_i(rst), .link(link),
		.index_i(index), .id_valid_i(id_valid), .id_c_i(id_chrn[31:24]), .id_h_i(id_chrn[23:16]),
		.id_r_i(id_chrn[15:8]), .id_n_i(id_chrn[7:0]), .id_crc_ok_i(crc_ok), .mark_valid_i(mark_valid),
		.mark_deleted_i(mark_del), .rd_valid_i(rd_valid), .rd_byte_i(rd_byte), .byte_tick_i(byte_tick),
		.head_load_o(head_load), .head_sel_o(head_sel), .mfm_o(mfm), .wr_gate_o(wr_gate),
		.wr_strobe_o(wr_strobe),
		.wr_mark_o(wr_mark), .wr_byte_o(wr_byte));
	fdc_host_end fdc_host_end_i (.ref_clk_i(clk), .rst_i(rst), .link(link), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
	fdc_link_checker fdc_link_checker_i (.ref_clk_i(clk), .rst_i(rst), .cmd_valid(link.cmd_valid),
		.cmd_byte(link.cmd_byte), .drq(link.drq), .to_host(link.to_host), .dack(link.dack),
		.dev_data(link.dev_data), .tc(link.tc), .res_valid(link.res_valid), .res_byte(link.res_byte),
		.busy(link.busy));
	// ------
	// clock, drive byte clock, monitor
	// ------
	always #20 clk = ~clk;
	always @(posedge clk)
	begin
		tick_q <= tick_q + 2'h1;
		byte_tick <= (tick_q == 2'h0);
		if (wr_strobe && wq.size() > 0)
			check({wr_mark, wr_byte}, wq.pop_front());
		if (link.res_valid && sq.size() > 0)
			check({2'h0, link.res_byte}, sq.pop_front());
		if (link.dack && link.to_host && rq.size() > 0)
			check({2'h0, link.dev_data}, rq.pop_front());
	end
	// ------
	// tasks
	// ------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check(input logic [9:0] s, input logic [9:0] e);
		if (!e[9])
		begin
			n_tests++;
			if (s !== e)
			begin
				fails++;
				$display("wrong value at %0t: seen %h, expected %h", $time, s, e);
			end
		end
	endtask
	task stop_test;
		$display("comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task sw_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task sw_rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task send_cmd;
		foreach (cb[i])
			sw_wr(4'h0, cb[i]);
		repeat (20) @(posedge clk);
	endtask
	task id(input logic [31:0] chrn, input logic ok);
		@(posedge clk);
		id_chrn <= chrn;
		crc_ok <= ok;
		id_valid <= 1'b1;
		@(posedge clk);
		id_valid <= 1'b0;
		id_chrn <= ~chrn;
		repeat (6) @(posedge clk);
	endtask
	task idx;
		@(posedge clk);
		index <= 1'b1;
		repeat (4) @(posedge clk);
		index <= 1'b0;
		repeat (30) @(posedge clk);
	endtask
	task mark(input logic del);
		@(posedge clk);
		mark_del <= del;
		mark_valid <= 1'b1;
		@(posedge clk);
		mark_valid <= 1'b0;
	endtask
	task rbyte;
		seed = lfsr(seed);
		@(posedge clk);
		rd_byte <= seed[7:0];
		rd_valid <= 1'b1;
		rq.push_back({2'h0, seed[7:0]});
		@(posedge clk);
		rd_valid <= 1'b0;
		rd_byte <= ~seed[7:0];
		repeat (5) @(posedge clk);
		sw_rd(4'h1);
		check({2'h0, v}, {2'h0, seed[7:0]});
	endtask
	task end_op(input string nm);
		for (int k = 0; k < 3000 && link.busy !== 1'b0; k++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		check(10'(sq.size() + wq.size() + rq.size()), 10'h000);
		$display("test %s done", nm);
	endtask
	task wr_test(input logic [7:0] b0, input logic hd, input logic [7:0] r, input logic [23:0] chr, input int mode);
		logic [9:0] x;
		logic [7:0] d;
		x = (mode != 0) ? 10'h200 : 10'h000;
		seed = lfsr(seed);
		d = seed[7:0];
		cb = '{b0, {5'h00, hd, 2'h0}, 8'h02, {7'h00, hd}, r, 8'h00, 8'h05, 8'h1b, 8'hff};
		sq = '{{3'h0, mode != 0, 3'h0, hd, 2'h0}, (mode == 1) ? 10'h010 : (mode == 2) ? 10'h020 : 10'h000,
			x, x | {2'h0, chr[23:16]}, x | {2'h0, chr[15:8]}, x | {2'h0, chr[7:0]}, x};
		send_cmd;
		id({8'h02, 7'h00, hd, r, 8'h01}, 1'b1);
		sw_rd(4'h2);
		check(10'({wr_gate, v[1]}), 10'h000);
		check({7'h00, head_load, head_sel, mfm}, {7'h00, 1'b1, hd, b0[6]});
		if (mode == 0)
		begin
			wq.push_back({(b0[4:0] == 5'h09) ? MARK_DELETED : MARK_DATA, 8'h00});
			wq.push_back({MARK_NONE, d});
			repeat (254) wq.push_back({MARK_NONE, 8'h00});
			sw_wr(4'h3, 8'h01);
			sw_wr(4'h1, d);
		end
		id({8'h02, 7'h00, hd, r, 8'h00}, mode != 2);
		end_op("write");
	endtask
	// ------
	// main sequence
	// ------
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		stop_test;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wr_test(8'h45, 1'b0, 8'h03, 24'h020004, 0);
		wr_test(8'h49, 1'b1, 8'h05, 24'h030101, 0);
		wr_test(8'hc5, 1'b0, 8'h05, 24'h020101, 0);
		wr_test(8'hc9, 1'b1, 8'h05, 24'h030001, 0);
		wr_test(8'h45, 1'b0, 8'h03, 24'h000000, 1);
		wr_test(8'h45, 1'b1, 8'h03, 24'h000000, 2);
		cb = '{8'h4a, 8'h00};
		sq = '{10'h000, 10'h000, 10'h000, 10'h007, 10'h000, 10'h009, 10'h002};
		send_cmd;
		id(32'h07000802, 1'b0);
		id(32'h07000902, 1'b1);
		end_op("read id");
		sw_rd(4'hd);
		check({2'h0, v}, 10'h009);
		sq = '{10'h040, 10'h005, 10'h200, 10'h200, 10'h200, 10'h200, 10'h200};
		send_cmd;
		idx;
		idx;
		end_op("missing id");
		cb = '{8'h4c, 8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h05, 8'h1b, 8'hff};
		sq = '{10'h200, 10'h200, 10'h040, 10'h002, 10'h000, 10'h200, 10'h000};
		send_cmd;
		id(32'h02000300, 1'b1);
		mark(1'b0);
		repeat (255) rbyte;
		end_op("read deleted");
		cb = '{8'h6c, 8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h05, 8'h1b, 8'hff};
		sq = '{10'h040, 10'h004, 10'h000, 10'h002, 10'h000, 10'h004, 10'h000};
		send_cmd;
		id(32'h02000300, 1'b1);
		mark(1'b0);
		idx;
		idx;
		end_op("skip");
		cb = '{8'h42, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h02, 8'h1b, 8'h02};
		sq = '{10'h000, 10'h000, 10'h000, 10'h002, 10'h000, 10'h001, 10'h000};
		send_cmd;
		idx;
		id(32'h02000100, 1'b1);
		mark(1'b1);
		repeat (2) rbyte;
		id(32'h02000200, 1'b0);
		mark(1'b0);
		repeat (2) rbyte;
		end_op("read track");
		cb = '{8'h4d, 8'h00, 8'h00, 8'h01, 8'h03, 8'he5};
		sq = '{10'h000, 10'h000, 10'h000, 10'h005, 10'h000, 10'h008, 10'h000};
		send_cmd;
		cb = '{8'h05, 8'h00, 8'h07, 8'h00};
		repeat (3) wq.push_back(10'h04e);
		wq.push_back({MARK_ID, 8'h00});
		foreach (cb[i])
			wq.push_back({2'h0, cb[i]});
		repeat (3) wq.push_back(10'h04e);
		wq.push_back({MARK_DATA, 8'h00});
		repeat (128) wq.push_back(10'h0e5);
		idx;
		foreach (cb[i])
			sw_wr(4'h1, cb[i]);
		repeat (600) @(posedge clk);
		idx;
		end_op("format");
		stop_test;
	end
endmodule
